// ### src/air_pkg.sv
package air_pkg;
	// word addressing of the io area, keyed by the unit number
	localparam logic [15:0] IO_LOW_BASE  = 16'h0064; // 100
	localparam logic [15:0] IO_HIGH_BASE = 16'h0190; // 400
	localparam logic [15:0] IO_STRIDE    = 16'h000A; // ten words per unit
	localparam logic [3:0]  UNIT_SPLIT   = 4'hA;     // first unit of the high bank
	// setup area base and stride per unit
	localparam logic [15:0] SU_BASE      = 16'h03E8;
	localparam logic [15:0] SU_STRIDE    = 16'h0064;
	// offsets inside the io area
	localparam logic [15:0] IO_PEAK_OFS  = 16'h0000; // control word from the host
	localparam logic [15:0] IO_RES_OFS   = 16'h0001; // first result word
	localparam logic [15:0] IO_STAT_OFS  = 16'h0009; // warning and wire status
	// offsets inside the setup area
	localparam logic [15:0] SU_FMT_OFS   = 16'h0000;
	localparam logic [15:0] SU_RNG_OFS   = 16'h0001;
	localparam logic [15:0] SU_SA_OFS    = 16'h0002;
	localparam logic [15:0] SU_RL_OFS    = 16'h0003;
	localparam logic [15:0] SU_IST_OFS   = 16'h002C; // interrupt status, write one to clear
	localparam logic [15:0] SU_IMSK_OFS  = 16'h002D; // interrupt mask
	// field positions
	localparam int          NUM_CH       = 8;
	localparam int          HI_LSB       = 8;  // upper byte enables
	localparam int          FMT_BIT      = 8;  // one selects binary
	localparam int          WMODE_BIT    = 9;  // one latches warnings
	localparam int          SIGN_BIT     = 15;
	// value spans in counts and in result words
	localparam logic [13:0] UNI_MAX      = 14'h0FA0;
	localparam logic [13:0] BIP_MAX      = 14'h07D0;
	localparam logic [23:0] ROOT_GAIN    = 24'h00_0FA0;
	localparam logic [15:0] RST_WORD     = 16'h0000;
	// input range codes of the range setup word
	typedef enum logic [1:0] {
		AIR_RNG_BIP10 = 2'b00,
		AIR_RNG_UNI10 = 2'b01,
		AIR_RNG_UNI5  = 2'b10
	} air_range_t;
	// register port request
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [15:0] wdata;
	} air_req_t;
	// one conversion from the converter front end
	typedef struct packed {
		logic              valid;
		logic [2:0]        chan;
		logic signed [12:0] value;
	} air_conv_t;
endpackage

// ### src/air_unit.sv
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/10ps
// How it works
// - unipolar BCD results span 0000 to 4000
// - unipolar binary results span 0000 to 0FA0
// - bipolar BCD: A000..8001 negative, 0000..2000 positive
// - bipolar binary: 87D0..8001 negative, 0000..07D0 positive
// - bipolar results carry sign in bit 15
// - scaling or root results carry no sign
// - enabled processing replaces raw value in result
// - limit check sets status bits 15..8
// - broken wire sets status bits 7..0
// - units 10..15 base at 400 plus ten each
// - range code decodes bipolar, 0..10V, 1..5V; the last two share one unipolar span
// - scaled results always written in BCD
module air_unit #(
	parameter int               AVG_SHIFT = 2,
	parameter logic signed [13:0] WARN_LO = 14'sh0000,
	parameter logic signed [13:0] WARN_HI = 14'sh0FA0
) (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               nrst,
	// register port
	input  wire air_pkg::air_req_t  req,
	output wire logic [15:0]        rdata,
	// unit number strap pins
	input  wire logic [3:0]         unit_sel,
	// converter front end
	input  wire air_pkg::air_conv_t conv,
	// wire break detector pins
	input  wire logic [7:0]         wire_break,
	// interrupt
	output wire logic               irq
);
	// whole state of the block
	typedef struct packed {
		logic [3:0]        unit_s1;  // strap synchroniser
		logic [3:0]        unit_s2;
		logic [7:0]        brk_s1;   // wire break synchroniser
		logic [7:0]        brk_s2;
		logic [15:0]       peak_ctl; // peak hold requests
		logic [15:0]       su_fmt;   // inhibits, format, mode
		logic [15:0]       su_rng;   // two bits per channel
		logic [15:0]       su_sa;    // scale and average enables
		logic [15:0]       su_rl;    // root and limit enables
		logic [7:0]        warn;     // limit warning flags
		logic [15:0]       irq_st;   // sticky events
		logic [15:0]       irq_mask;
		logic [7:0][15:0]  result;   // result words
		logic [7:0][13:0]  avg;      // running means
		logic [7:0][13:0]  peak;     // held peaks
		logic [15:0]       rdata;
	} air_state_t;

	air_state_t q;   // registered state
	air_state_t d;   // next state

	// io area base word for a unit number
	function automatic logic [15:0] air_io_base(input logic [3:0] u);
		if (u < air_pkg::UNIT_SPLIT)
			return air_pkg::IO_LOW_BASE + air_pkg::IO_STRIDE * {12'h000, u};
		else
			return air_pkg::IO_HIGH_BASE
				+ air_pkg::IO_STRIDE * {12'h000, u - air_pkg::UNIT_SPLIT};
	endfunction

	// setup area base word for a unit number
	function automatic logic [15:0] air_su_base(input logic [3:0] u);
		return air_pkg::SU_BASE + air_pkg::SU_STRIDE * {12'h000, u};
	endfunction

	// binary to four bcd digits by shift and add three
	function automatic logic [15:0] air_bcd(input logic [12:0] b);
		logic [28:0] s;
		s = {16'h0000, b};
		for (int i = 0; i < 13; i++)
		begin
			for (int k = 0; k < 4; k++)
			begin
				if (s[13+4*k +: 4] > 4'h4)
					s[13+4*k +: 4] = s[13+4*k +: 4] + 4'h3;
			end
			s = s << 1;
		end
		return s[28:13];
	endfunction

	// integer square root, bit by bit; deep logic but no extra state
	function automatic logic [11:0] air_sqrt(input logic [23:0] x);
		logic [11:0] r;
		logic [23:0] t;
		r = 12'h000;
		t = 24'h00_0000;
		for (int i = 11; i >= 0; i--)
		begin
			t = {12'h000, r | (12'h001 << i)};
			if (t * t <= x)
				r = r | (12'h001 << i);
		end
		return r;
	endfunction

	// refuse settings the mean filter and the limit check cannot serve
	if (AVG_SHIFT < 1 || AVG_SHIFT > 8)
		$error("air_unit: AVG_SHIFT must be 1 to 8");
	if (WARN_LO > WARN_HI)
		$error("air_unit: WARN_LO above WARN_HI");

	logic [15:0] io_base;   // current io base word
	logic [15:0] su_base;   // current setup base word
	logic [15:0] io_rel;    // address relative to io base
	logic [15:0] su_rel;    // address relative to setup base

	// bases follow the synchronised strap
	always_comb
	begin
		io_base = air_io_base(q.unit_s2);
		su_base = air_su_base(q.unit_s2);
		io_rel  = req.addr - io_base;
		su_rel  = req.addr - su_base;
	end

	// next state: bus, conversion path, flags and interrupts
	always_comb
	begin
		logic [2:0]         ch;
		logic               bip;
		logic               inh;
		logic               en_sc;
		logic               en_av;
		logic               en_rt;
		logic               en_lm;
		logic               fmt_bin;
		logic signed [13:0] v;
		logic signed [13:0] a;
		logic signed [13:0] p;
		logic [12:0]        m;
		logic [15:0]        w;
		logic               out_rng;
		logic [15:0]        clr;
		logic [15:0]        st_new;
		logic [15:0]        st_old;
		ch      = conv.chan;
		bip     = 1'b0;
		inh     = 1'b0;
		en_sc   = 1'b0;
		en_av   = 1'b0;
		en_rt   = 1'b0;
		en_lm   = 1'b0;
		fmt_bin = 1'b0;
		v       = 14'sh0000;
		a       = 14'sh0000;
		p       = 14'sh0000;
		m       = 13'h0000;
		w       = air_pkg::RST_WORD;
		out_rng = 1'b0;
		clr     = 16'h0000;
		st_new  = 16'h0000;
		st_old  = 16'h0000;
		d       = q;
		// pins pass two flops before use
		d.unit_s1 = unit_sel;
		d.unit_s2 = q.unit_s1;
		d.brk_s1  = wire_break;
		d.brk_s2  = q.brk_s1;
		// read data stand for one cycle only
		d.rdata   = air_pkg::RST_WORD;

		// register writes; unmapped writes are dropped
		if (req.wr)
		begin
			if (io_rel == air_pkg::IO_PEAK_OFS)
				d.peak_ctl = {8'h00, req.wdata[7:0]};
			else if (su_rel == air_pkg::SU_FMT_OFS)
				d.su_fmt = req.wdata;
			else if (su_rel == air_pkg::SU_RNG_OFS)
				d.su_rng = req.wdata;
			else if (su_rel == air_pkg::SU_SA_OFS)
				d.su_sa = req.wdata;
			else if (su_rel == air_pkg::SU_RL_OFS)
				d.su_rl = req.wdata;
			else if (su_rel == air_pkg::SU_IST_OFS)
				clr = req.wdata;
			else if (su_rel == air_pkg::SU_IMSK_OFS)
				d.irq_mask = req.wdata;
		end

		// register reads; unmapped reads answer zero
		if (req.rd)
		begin
			if (io_rel == air_pkg::IO_PEAK_OFS)
				d.rdata = q.peak_ctl;
			else if (io_rel >= air_pkg::IO_RES_OFS && io_rel < air_pkg::IO_STAT_OFS)
				d.rdata = q.result[3'(io_rel - air_pkg::IO_RES_OFS)];
			else if (io_rel == air_pkg::IO_STAT_OFS)
				d.rdata = {q.warn, q.brk_s2};
			else if (su_rel == air_pkg::SU_FMT_OFS)
				d.rdata = q.su_fmt;
			else if (su_rel == air_pkg::SU_RNG_OFS)
				d.rdata = q.su_rng;
			else if (su_rel == air_pkg::SU_SA_OFS)
				d.rdata = q.su_sa;
			else if (su_rel == air_pkg::SU_RL_OFS)
				d.rdata = q.su_rl;
			else if (su_rel == air_pkg::SU_IST_OFS)
				d.rdata = q.irq_st;
			else if (su_rel == air_pkg::SU_IMSK_OFS)
				d.rdata = q.irq_mask;
		end

		// one conversion per valid cycle, channel picked by the front end
		if (conv.valid)
		begin
			// per channel setup decode
			bip     = (q.su_rng[2*ch +: 2] == air_pkg::AIR_RNG_BIP10);
			inh     = q.su_fmt[ch];
			fmt_bin = q.su_fmt[air_pkg::FMT_BIT];
			en_sc   = q.su_sa[air_pkg::HI_LSB + 32'(ch)];
			en_av   = q.su_sa[ch];
			en_rt   = q.su_rl[air_pkg::HI_LSB + 32'(ch)];
			en_lm   = q.su_rl[ch];
			// clamp the raw count into the range span
			v = 14'(conv.value);
			if (bip)
			begin
				if (v > $signed(air_pkg::BIP_MAX))
					v = $signed(air_pkg::BIP_MAX);
				else if (v < -$signed(air_pkg::BIP_MAX))
					v = -$signed(air_pkg::BIP_MAX);
			end
			else
			begin
				if (v < 14'sh0000)
					v = 14'sh0000;
				else if (v > $signed(air_pkg::UNI_MAX))
					v = $signed(air_pkg::UNI_MAX);
			end
			// running mean; when off it tracks the input for a clean start
			a = $signed(q.avg[ch]);
			if (en_av)
				a = a + ((v - a) >>> AVG_SHIFT);
			else
				a = v;
			p = a;
			// peak hold on the possibly averaged value
			if (q.peak_ctl[ch] && $signed(q.peak[ch]) > p)
				p = $signed(q.peak[ch]);
			// square root, scaled back onto the full span
			if (en_rt)
				p = 14'(air_sqrt((p < 14'sh0000 ? 24'h00_0000 : 24'(p)) * air_pkg::ROOT_GAIN));
			// scaling limits are not held here: negative inputs clamp to zero
			if (en_sc && p < 14'sh0000)
				p = 14'sh0000;
			m = (p < 14'sh0000) ? 13'(-p) : 13'(p);
			// pack the word
			if (en_sc)
				w = air_bcd(m);
			else if (en_rt)
				w = fmt_bin ? {3'b000, m} : air_bcd(m);
			else
			begin
				w = fmt_bin ? {3'b000, m} : air_bcd(m);
				if (bip && p < 14'sh0000)
					w[air_pkg::SIGN_BIT] = 1'b1;
			end
			// limit check on the processed value
			out_rng = (p < WARN_LO) || (p > WARN_HI);
			if (inh)
			begin
				// inhibited channel shows zero and keeps its filters
				d.result[ch] = air_pkg::RST_WORD;
			end
			else
			begin
				d.result[ch] = w;
				d.avg[ch]    = a;
				d.peak[ch]   = p;
				if (en_lm && q.su_fmt[air_pkg::WMODE_BIT])
					d.warn[ch] = q.warn[ch] | out_rng;
				else if (en_lm)
					d.warn[ch] = out_rng;
			end
		end

		// a channel with its check off shows no warning
		for (int i = 0; i < air_pkg::NUM_CH; i++)
		begin
			if (!q.su_rl[i])
				d.warn[i] = 1'b0;
		end

		// rising status bits set sticky events; set wins over clear
		st_new   = {d.warn, d.brk_s2};
		st_old   = {q.warn, q.brk_s2};
		d.irq_st = (q.irq_st & ~clr) | (st_new & ~st_old);
	end

	// state register
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			q <= '0;
		else
			q <= d;
	end

	// outputs
	assign rdata = q.rdata;
	assign irq   = |(q.irq_st & q.irq_mask);

	// helpers seen only by the checks below
	logic plain0;  // raw conversion on channel one
	logic bin_sel; // binary format chosen
	logic uni0;    // channel one on a unipolar range
	assign plain0  = conv.valid && conv.chan == 3'h0 && !q.su_fmt[0] && !q.su_sa[8]
		&& !q.su_sa[0] && !q.su_rl[8] && !q.peak_ctl[0];
	assign bin_sel = q.su_fmt[air_pkg::FMT_BIT];
	assign uni0    = q.su_rng[1:0] != 2'b00;

	default clocking air_cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	AST_UNI_BIN: assert property (
		plain0 && uni0 && bin_sel |=> q.result[0] <= 16'h0FA0)
		else $error("unipolar binary result above span");
	AST_UNI_BCD: assert property (
		plain0 && uni0 && !bin_sel |=> q.result[0] <= 16'h4000 && q.result[0][3:0] <= 4'h9)
		else $error("unipolar bcd result out of span");
	AST_BIP_BCD: assert property (
		plain0 && !uni0 && !bin_sel && conv.value < 0
		|=> q.result[0] >= 16'h8001 && q.result[0] <= 16'hA000)
		else $error("bipolar bcd negative result out of span");
	AST_BIP_BIN: assert property (
		plain0 && !uni0 && bin_sel && conv.value >= 0 |=> q.result[0] <= 16'h07D0)
		else $error("bipolar binary positive result out of span");
	AST_SIGN: assert property (
		plain0 && !uni0 && bin_sel && conv.value < 0 && conv.value > -13'sd2000
		|=> q.result[0] == {3'b100, $past(-conv.value)})
		else $error("bipolar sign or magnitude wrong");
	AST_NO_SIGN: assert property (
		conv.valid && conv.chan == 3'h0 && !q.su_fmt[0] && (q.su_sa[8] || q.su_rl[8])
		|=> !q.result[0][15])
		else $error("sign flag present under scaling or root");
	AST_SCALE_BCD: assert property (
		conv.valid && conv.chan == 3'h0 && !q.su_fmt[0] && q.su_sa[8] && bin_sel
		|=> q.result[0][3:0] <= 4'h9 && q.result[0][7:4] <= 4'h9 && q.result[0] <= 16'h4000)
		else $error("scaled result not bcd");
	AST_WARN: assert property (
		plain0 && q.su_rl[0] && !uni0 && conv.value < 13'(WARN_LO)
		|=> q.warn[0] ##1 (q.warn[0] || !$past(q.su_rl[0]) || $past(conv.valid)))
		else $error("limit warning not raised");
	AST_WARN_OFF: assert property (
		!q.su_rl[0] |=> !q.warn[0])
		else $error("warning shown with check disabled");
	AST_BREAK: assert property (
		$stable(wire_break) [*3] |-> q.brk_s2 == wire_break)
		else $error("wire break status does not follow pins");
	AST_STATUS_READ: assert property (
		req.rd && req.addr == air_io_base(q.unit_s2) + air_pkg::IO_STAT_OFS
		|=> rdata == $past({q.warn, q.brk_s2}))
		else $error("status word not at unit base plus nine");
	AST_IRQ: assert property (
		$rose(q.brk_s2[0]) && q.irq_mask[0] |-> irq)
		else $error("interrupt missing on wire break");
endmodule // air_unit

// ### tb/air_host_model.sv
`timescale 1ns/10ps
// controller side of the word bus: owns the strobes and the unit addressing
module air_host_model (
	// clock
	input  wire logic              clk,
	// word bus toward the unit
	output air_pkg::air_req_t      req,
	input  wire logic [15:0]       rdata
);
	// bus idles from time zero so the unit never sees a stray strobe
	initial req = '0;

	// io area base word of a unit number
	function automatic logic [15:0] base_of(input logic [3:0] u);
		if (u < 4'hA)
			return 16'h0064 + 16'h000A * {12'h000, u};
		return 16'h0190 + 16'h000A * {12'h000, u - 4'hA};
	endfunction

	// one write cycle; strobe dropped at the next edge, so calls leave one idle cycle
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		req <= '0;
	endtask

	// read data stand only in the cycle after the strobe edge, so sample just inside it
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge clk);
		req <= '0;
		#1 d = rdata;
	endtask

	// peak request word: the upper byte is always left clear
	task automatic wr_peak(input logic [3:0] u, input logic [7:0] bits);
		wr(base_of(u), {8'h00, bits});
	endtask
endmodule // air_host_model

// ### tb/tb_top.sv
`timescale 1ns/10ps
// bench: host model on the word bus, bench drives converter, straps and wire pins
module tb_top;
	localparam logic [15:0] N = 16'h0064; // io base of unit zero
	localparam logic [15:0] M = 16'h03E8; // setup base of unit zero

	logic               clk;        // 125 MHz clock
	logic               nrst;       // async reset, active low
	air_pkg::air_req_t  req;        // word bus from host model
	logic [15:0]        rdata;      // read data back to host
	logic [3:0]         unit_sel;   // unit number straps
	air_pkg::air_conv_t conv;       // converter samples
	logic [7:0]         wire_break; // broken wire pins
	logic               irq;        // interrupt level
	logic [15:0]        rv;         // last word read
	logic [3:0]         units [3];  // unit numbers to visit
	int                 err_count;  // mismatches
	int                 checked;    // comparisons made
	int                 cyc;        // cycles since start

	// clock generator
	initial clk = 1'b0;
	always #4 clk = ~clk;

	air_unit uut (
		.clk        (clk),
		.nrst       (nrst),
		.req        (req),
		.rdata      (rdata),
		.unit_sel   (unit_sel),
		.conv       (conv),
		.wire_break (wire_break),
		.irq        (irq)
	);

	air_host_model host (
		.clk   (clk),
		.req   (req),
		.rdata (rdata)
	);

	// compare one word, report at once on a mismatch
	task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one converter sample, valid for a single cycle
	task automatic cv(input logic [2:0] ch, input logic signed [12:0] v);
		@(posedge clk);
		conv <= '{valid: 1'b1, chan: ch, value: v};
		@(posedge clk);
		conv <= '0;
	endtask

	// set format and range words, convert on input one and compare its result word
	task automatic conv_chk(input logic [15:0] fw, input logic [15:0] rw,
		input logic signed [12:0] v, input logic [15:0] e);
		host.wr(M, fw);
		host.wr(M + 16'h0001, rw);
		cv(3'h0, v);
		host.rd(N + 16'h0001, rv);
		chk("input one result", rv, e);
	endtask

	// counts, verdict, end of run
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// hang guard: the whole sequence needs well under a thousand cycles
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			err_count++;
			finish_test();
		end
	end

	// main sequence
	initial
	begin
		nrst = 1'b0;
		conv = '0;
		unit_sel = 4'h0;
		wire_break = 8'h00;
		err_count = 0;
		checked = 0;
		cyc = 0;
		units = '{4'h9, 4'hA, 4'hF};
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		// quiet after reset, unmapped word reads zero
		host.rd(N + 16'h0009, rv);
		chk("status after reset", rv, 16'h0000);
		chk("irq after reset", {15'h0000, irq}, 16'h0000);
		host.rd(16'h0005, rv);
		chk("unmapped word", rv, 16'h0000);
		// every range code in both formats, span ends and sign
		conv_chk(16'h0000, 16'h0000, -13'sh07D0, 16'hA000);
		conv_chk(16'h0000, 16'h0000, -13'sh0001, 16'h8001);
		conv_chk(16'h0000, 16'h0000, 13'sh07D0, 16'h2000);
		conv_chk(16'h0100, 16'h0000, -13'sh07D0, 16'h87D0);
		conv_chk(16'h0100, 16'h0000, -13'sh0001, 16'h8001);
		conv_chk(16'h0100, 16'h0000, 13'sh07D0, 16'h07D0);
		conv_chk(16'h0000, 16'h0001, 13'sh0FA0, 16'h4000);
		conv_chk(16'h0100, 16'h0001, 13'sh0FA0, 16'h0FA0);
		conv_chk(16'h0100, 16'h0002, 13'sh0000, 16'h0000);
		conv_chk(16'h0000, 16'h0002, 13'sh04D2, 16'h1234);
		// result words ignore writes
		host.wr(N + 16'h0001, 16'h5555);
		host.rd(N + 16'h0001, rv);
		chk("result after write", rv, 16'h1234);
		// inhibited input reads zero
		conv_chk(16'h0001, 16'h0000, 13'sh01F4, 16'h0000);
		// scaling: BCD even with binary selected, negatives clamp to zero, no sign
		host.wr(M + 16'h0002, 16'h0100);
		conv_chk(16'h0100, 16'h0000, 13'sh04D2, 16'h1234);
		conv_chk(16'h0100, 16'h0000, -13'sh04D2, 16'h0000);
		// square root replaces the raw value and never carries a sign
		host.wr(M + 16'h0002, 16'h0000);
		host.wr(M + 16'h0003, 16'h0100);
		conv_chk(16'h0100, 16'h0001, 13'sh03E8, 16'h07D0);
		conv_chk(16'h0000, 16'h0000, -13'sh0005, 16'h0000);
		// limit warning on input three, following then latched
		host.wr(M + 16'h0003, 16'h0004);
		cv(3'h2, -13'sh0005);
		host.rd(N + 16'h0009, rv);
		chk("warning set", rv, 16'h0400);
		cv(3'h2, 13'sh0064);
		host.rd(N + 16'h0009, rv);
		chk("warning follows", rv, 16'h0000);
		host.wr(M, 16'h0200);
		cv(3'h2, -13'sh0005);
		cv(3'h2, 13'sh0064);
		host.rd(N + 16'h0009, rv);
		chk("warning latched", rv, 16'h0400);
		host.wr(M + 16'h0003, 16'h0000);
		host.rd(N + 16'h0009, rv);
		chk("warning cleared", rv, 16'h0000);
		// limit warning on input one as well
		host.wr(M + 16'h0003, 16'h0001);
		cv(3'h0, -13'sh0005);
		host.rd(N + 16'h0009, rv);
		chk("input one warning", rv, 16'h0100);
		host.wr(M + 16'h0003, 16'h0000);
		// broken wires, sticky status, mask and clear
		host.wr(M + 16'h002C, 16'hFFFF);
		@(posedge clk);
		wire_break <= 8'h81;
		repeat (4) @(posedge clk);
		host.rd(N + 16'h0009, rv);
		chk("broken wires", rv, 16'h0081);
		chk("irq masked", {15'h0000, irq}, 16'h0000);
		host.rd(M + 16'h002C, rv);
		chk("irq status", rv, 16'h0081);
		host.wr(M + 16'h002D, 16'h0080);
		#1 chk("irq unmasked", {15'h0000, irq}, 16'h0001);
		@(posedge clk);
		wire_break <= 8'h00;
		repeat (4) @(posedge clk);
		host.wr(M + 16'h002C, 16'h0080);
		#1 chk("irq cleared", {15'h0000, irq}, 16'h0000);
		host.rd(M + 16'h002C, rv);
		chk("irq status left", rv, 16'h0001);
		// a break on input one with its mask bit set raises the interrupt
		host.wr(M + 16'h002C, 16'h0001);
		host.wr(M + 16'h002D, 16'h0001);
		@(posedge clk);
		wire_break <= 8'h01;
		repeat (4) @(posedge clk);
		chk("irq on break", {15'h0000, irq}, 16'h0001);
		wire_break <= 8'h00;
		repeat (4) @(posedge clk);
		host.wr(M + 16'h002C, 16'h0001);
		#1 chk("irq on break cleared", {15'h0000, irq}, 16'h0000);
		// peak request word reads back
		host.wr_peak(4'h0, 8'h80);
		host.rd(N, rv);
		chk("peak word", rv, 16'h0080);
		host.wr_peak(4'h0, 8'h00);
		// mean on input one: a quarter of the step per sample
		conv_chk(16'h0000, 16'h0001, 13'sh0000, 16'h0000);
		host.wr(M + 16'h0002, 16'h0001);
		conv_chk(16'h0000, 16'h0001, 13'sh0190, 16'h0100);
		host.wr(M + 16'h0002, 16'h0000);
		// peak hold keeps the largest value while its request bit is set
		host.wr_peak(4'h0, 8'h01);
		conv_chk(16'h0000, 16'h0001, 13'sh0032, 16'h0100);
		conv_chk(16'h0000, 16'h0001, 13'sh00C8, 16'h0200);
		host.wr_peak(4'h0, 8'h00);
		// unit numbers move the io area
		conv_chk(16'h0000, 16'h0000, 13'sh0007, 16'h0007);
		foreach (units[i])
		begin
			@(posedge clk);
			unit_sel <= units[i];
			repeat (4) @(posedge clk);
			host.rd(host.base_of(units[i]) + 16'h0001, rv);
			chk("result at unit base", rv, 16'h0007);
		end
		finish_test();
	end
endmodule // tb_top
